//--- rtl/swgc_global_ctrl.sv
// Global forwarding policy and VLAN/snoop control registers of a
// small managed switch, with the frame policy stage they steer.
// Assumes a synchronous register port and core clock at 40 MHz.
//
// Summary of operation
// - Bit 7 set blocks all frames crossing a port VLAN; clear lets only known unicast cross.
// - Storm regulation covers broadcast only when bit 6 is set, and DA bit 40 frames too when clear.
// - Bit 5 picks carrier-sense back pressure when one and collision back pressure when zero.
// - With the fairness bit set, frames from the non-flow-controlled contender may be dropped.
// - With the fairness bit clear, the flow-controlled contender is paused instead.
// - Bit 3 clear drops a frame after 16 or more collisions; set keeps retrying.
// - Huge frame bit set accepts frames up to 1916 bytes regardless of bit 1.
// - Otherwise bit 1 set accepts frames up to 1536 bytes.
// - Both clear limits tagged frames to 1522 and untagged to 1518, special tag exempt.
// - Bit 7 of the next register turns 802.1q VLAN forwarding on or off.
// - Bit 6 of the next register sends all IGMP frames to the host side MII port.
`timescale 1ns/10ps
`default_nettype none
module swgc_global_ctrl
   import swgc_pkg::*;
(
   input wire logic clock,                     // Core clock, 40 MHz
   input wire logic rst_n,                     // Sync reset, active low
   input wire logic collision_policy_strap_pin,// Strap for bit 3
   input wire logic [7:0] reg_addr,            // Register address
   input wire logic reg_wr,                    // Write strobe
   input wire logic [7:0] reg_wdata,           // Write data
   input wire logic reg_rd,                    // Read strobe
   output logic [7:0] reg_rdata,               // Read data, next cycle
   input wire logic frm_valid,                 // Frame descriptor strobe
   input wire logic [10:0] frm_len,            // Frame length bytes
   input wire logic frm_tagged,                // Tagged frame
   input wire logic frm_special_tag,           // Processor special tag
   input wire logic frm_da_bcast,              // DA all ones
   input wire logic frm_da_bit40,              // DA bit 40
   input wire logic frm_known_ucast,           // Known unicast
   input wire logic frm_cross_vlan,            // Crosses port VLAN
   input wire logic frm_igmp,                  // IGMP frame
   input wire logic frm_src_fc,                // Source flow controlled
   input wire logic frm_contend,               // Egress contention
   input wire logic col_event,                 // Collision strobe
   input wire logic [4:0] col_count,           // Collision count
   output logic dec_valid,                     // Frame decision strobe
   output logic size_drop,                     // Drop, too long
   output logic vlan_cross_drop,               // Drop, VLAN crossing
   output logic storm_regulated,               // Counts toward storm
   output logic igmp_to_host,                  // Copy to host MII
   output logic fair_drop,                     // Drop non-FC source
   output logic pause_src,                     // Flow control source
   output logic col_valid,                     // Collision decision
   output logic excess_drop,                   // Discard frame
   output logic excess_retry,                  // Keep retrying
   output logic bp_carrier_mode,               // Back pressure style
   output logic vlan_forward_en,               // 802.1q forwarding on
   output logic igmp_snoop_en                  // Snooping on
);

   // ==========================================================
   // Register bank
   swgc_bank_t q;
   swgc_bank_t n;
   swgc_pol_t pol;
   swgc_cfg_if cfg ();

   // Next bank state
   always_comb
   begin
      n = q;
      // Strap capture in the first cycle after reset
      if (q.strap_pending)
      begin
         n.fwd[SWGC_B_NOEXC] = collision_policy_strap_pin;
         n.strap_pending = 1'b0;
      end
      // Software writes win over the strap capture
      if (reg_wr && (reg_addr == SWGC_OFS_FWD))
         n.fwd = reg_wdata & SWGC_FWD_MASK;
      if (reg_wr && (reg_addr == SWGC_OFS_VLN))
         n.vln = reg_wdata & SWGC_VLN_MASK;
      // Read data capture
      if (reg_rd)
      begin
         if (reg_addr == SWGC_OFS_FWD)
            n.rdata = q.fwd & SWGC_FWD_MASK;
         else if (reg_addr == SWGC_OFS_VLN)
            n.rdata = q.vln & SWGC_VLN_MASK;
         else
            n.rdata = SWGC_RD_NONE;
      end
   end

   // Bank register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         q.fwd <= SWGC_FWD_RST;
         q.vln <= SWGC_VLN_RST;
         q.rdata <= SWGC_RD_NONE;
         q.strap_pending <= 1'b1;
      end
      else
         q <= n;
   end

   // ==========================================================
   // Settings toward the policy stage
   assign cfg.discard_all_cross = q.fwd[SWGC_B_CROSS];
   assign cfg.storm_mc_off = q.fwd[SWGC_B_STORM];
   assign cfg.bp_carrier = q.fwd[SWGC_B_BP];
   assign cfg.fair = q.fwd[SWGC_B_FAIR];
   assign cfg.no_exc_drop = q.fwd[SWGC_B_NOEXC];
   assign cfg.huge = q.fwd[SWGC_B_HUGE];
   assign cfg.legal_off = q.fwd[SWGC_B_LEGAL];
   assign cfg.vlan_en = q.vln[SWGC_B_VLAN];
   assign cfg.igmp_snoop = q.vln[SWGC_B_IGMP];

   // Policy stage
   swgc_frame_policy u_policy (
      .clock(clock),
      .rst_n(rst_n),
      .cfg(cfg),
      .frm_valid(frm_valid),
      .frm_len(frm_len),
      .frm_tagged(frm_tagged),
      .frm_special_tag(frm_special_tag),
      .frm_da_bcast(frm_da_bcast),
      .frm_da_bit40(frm_da_bit40),
      .frm_known_ucast(frm_known_ucast),
      .frm_cross_vlan(frm_cross_vlan),
      .frm_igmp(frm_igmp),
      .frm_src_fc(frm_src_fc),
      .frm_contend(frm_contend),
      .col_event(col_event),
      .col_count(col_count),
      .pol_q(pol)
   );

   // ==========================================================
   // Outputs, all straight from flip-flops
   assign reg_rdata = q.rdata;
   assign dec_valid = pol.dec_valid;
   assign size_drop = pol.size_drop;
   assign vlan_cross_drop = pol.vlan_cross_drop;
   assign storm_regulated = pol.storm_regulated;
   assign igmp_to_host = pol.igmp_to_host;
   assign fair_drop = pol.fair_drop;
   assign pause_src = pol.pause_src;
   assign col_valid = pol.col_valid;
   assign excess_drop = pol.excess_drop;
   assign excess_retry = pol.excess_retry;
   assign bp_carrier_mode = pol.bp_carrier_mode;
   assign vlan_forward_en = pol.vlan_forward_en;
   assign igmp_snoop_en = pol.igmp_snoop_en;

endmodule : swgc_global_ctrl
`default_nettype wire

//--- rtl/swgc_pkg.sv
// Package for the switch global forwarding and VLAN control bank.
// Assumes a single 40 MHz core clock and a synchronous active-low reset.
package swgc_pkg;

   // ==========================================================
   // Register offsets and reset values
   localparam logic [7:0] SWGC_OFS_FWD = 8'h04;
   localparam logic [7:0] SWGC_OFS_VLN = 8'h05;
   localparam logic [7:0] SWGC_FWD_RST = 8'hF0;
   localparam logic [7:0] SWGC_FWD_MASK = 8'hFE;
   localparam logic [7:0] SWGC_VLN_RST = 8'h00;
   localparam logic [7:0] SWGC_VLN_MASK = 8'hC0;
   localparam logic [7:0] SWGC_RD_NONE = 8'h00;

   // ==========================================================
   // Field positions
   localparam int unsigned SWGC_B_CROSS = 7;
   localparam int unsigned SWGC_B_STORM = 6;
   localparam int unsigned SWGC_B_BP = 5;
   localparam int unsigned SWGC_B_FAIR = 4;
   localparam int unsigned SWGC_B_NOEXC = 3;
   localparam int unsigned SWGC_B_HUGE = 2;
   localparam int unsigned SWGC_B_LEGAL = 1;
   localparam int unsigned SWGC_B_VLAN = 7;
   localparam int unsigned SWGC_B_IGMP = 6;

   // ==========================================================
   // Frame length limits in bytes and collision limit
   localparam logic [10:0] SWGC_LEN_HUGE = 11'h77C;
   localparam logic [10:0] SWGC_LEN_LEGAL_OFF = 11'h600;
   localparam logic [10:0] SWGC_LEN_TAGGED = 11'h5F2;
   localparam logic [10:0] SWGC_LEN_UNTAGGED = 11'h5EE;
   localparam logic [4:0] SWGC_COL_LIMIT = 5'h10;

   // ==========================================================
   // State of the register bank
   typedef struct packed {
      logic [7:0] fwd;
      logic [7:0] vln;
      logic [7:0] rdata;
      logic strap_pending;
   } swgc_bank_t;

   // State of the frame policy stage
   typedef struct packed {
      logic dec_valid;
      logic size_drop;
      logic vlan_cross_drop;
      logic storm_regulated;
      logic igmp_to_host;
      logic fair_drop;
      logic pause_src;
      logic col_valid;
      logic excess_drop;
      logic excess_retry;
      logic bp_carrier_mode;
      logic vlan_forward_en;
      logic igmp_snoop_en;
   } swgc_pol_t;

endpackage : swgc_pkg

//--- rtl/swgc_cfg_if.sv
// Interface carrying decoded control settings from bank to policy stage.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
`default_nettype none
interface swgc_cfg_if;
   logic discard_all_cross;
   logic storm_mc_off;
   logic bp_carrier;
   logic fair;
   logic no_exc_drop;
   logic huge;
   logic legal_off;
   logic vlan_en;
   logic igmp_snoop;

   // Bank drives, policy stage reads
   modport ctl (output discard_all_cross, storm_mc_off, bp_carrier, fair,
      no_exc_drop, huge, legal_off, vlan_en, igmp_snoop);
   modport pol (input discard_all_cross, storm_mc_off, bp_carrier, fair,
      no_exc_drop, huge, legal_off, vlan_en, igmp_snoop);
endinterface : swgc_cfg_if
`default_nettype wire

//--- rtl/swgc_frame_policy.sv
// Frame policy stage: turns control settings and frame attributes
// into registered forwarding, filtering and MAC decisions.
// Assumes frame attributes are valid in the cycle frm_valid is high.
`timescale 1ns/10ps
`default_nettype none
module swgc_frame_policy
   import swgc_pkg::*;
(
   input wire logic clock,                // Core clock
   input wire logic rst_n,                // Sync reset, active low
   swgc_cfg_if.pol cfg,                   // Control settings
   input wire logic frm_valid,            // Frame descriptor strobe
   input wire logic [10:0] frm_len,       // Frame length in bytes
   input wire logic frm_tagged,           // Frame carries 802.1q tag
   input wire logic frm_special_tag,      // Processor special tag
   input wire logic frm_da_bcast,         // DA all ones
   input wire logic frm_da_bit40,         // DA bit 40 set
   input wire logic frm_known_ucast,      // Known unicast DA
   input wire logic frm_cross_vlan,       // Crosses port VLAN boundary
   input wire logic frm_igmp,             // Frame is IGMP
   input wire logic frm_src_fc,           // Source port is flow controlled
   input wire logic frm_contend,          // FC and non-FC share egress
   input wire logic col_event,            // Collision count strobe
   input wire logic [4:0] col_count,      // Collisions so far
   output swgc_pol_t pol_q                // Registered decisions
);

   swgc_pol_t q;
   swgc_pol_t n;
   logic [10:0] limit;

   // Next decisions
   always_comb
   begin
      n = '0;
      // Length ceiling selection
      if (cfg.huge)
         limit = SWGC_LEN_HUGE;
      else if (cfg.legal_off || frm_special_tag)
         limit = SWGC_LEN_LEGAL_OFF;
      else if (frm_tagged)
         limit = SWGC_LEN_TAGGED;
      else
         limit = SWGC_LEN_UNTAGGED;
      n.bp_carrier_mode = cfg.bp_carrier;
      n.vlan_forward_en = cfg.vlan_en;
      n.igmp_snoop_en = cfg.igmp_snoop;
      // Per frame decisions
      if (frm_valid)
      begin
         n.dec_valid = 1'b1;
         n.size_drop = (frm_len > limit);
         n.vlan_cross_drop = frm_cross_vlan &&
            (cfg.discard_all_cross || !frm_known_ucast);
         n.storm_regulated = frm_da_bcast ||
            (!cfg.storm_mc_off && frm_da_bit40);
         n.igmp_to_host = frm_igmp && cfg.igmp_snoop;
         n.fair_drop = frm_contend && cfg.fair && !frm_src_fc;
         n.pause_src = frm_contend && !cfg.fair && frm_src_fc;
      end
      // Excessive collision handling
      if (col_event)
      begin
         n.col_valid = 1'b1;
         n.excess_drop = (col_count >= SWGC_COL_LIMIT) &&
            !cfg.no_exc_drop;
         n.excess_retry = !n.excess_drop;
      end
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= n;
   end

   assign pol_q = q;

endmodule : swgc_frame_policy
`default_nettype wire

//--- sim/swgc_global_ctrl_monitor.sv
// Checker of the global control bank as seen at its top ports.
// Assumes binding into swgc_global_ctrl, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module swgc_global_ctrl_monitor
(
   input wire logic clock,           // Core clock
   input wire logic rst_n,           // Sync reset
   input wire logic [7:0] reg_addr,  // Address
   input wire logic reg_wr,          // Write strobe
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_rd,          // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic frm_valid,       // Frame strobe
   input wire logic [10:0] frm_len,  // Length
   input wire logic frm_da_bcast,    // Broadcast
   input wire logic frm_known_ucast, // Known unicast
   input wire logic frm_cross_vlan,  // Crosses VLAN
   input wire logic col_event,       // Collision strobe
   input wire logic [4:0] col_count, // Collisions
   input wire logic dec_valid,       // Decision strobe
   input wire logic size_drop,       // Too long
   input wire logic vlan_cross_drop, // VLAN drop
   input wire logic storm_regulated, // Storm class
   input wire logic col_valid,       // Collision decision
   input wire logic excess_drop      // Discard
);
   // ==========================================================
   // Properties
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_dec_next;
      ##1 dec_valid;
   endsequence
   sequence s_wr_vln;
      reg_wr && reg_addr == 8'h05;
   endsequence
   sequence s_rd_vln;
      reg_rd && !reg_wr && reg_addr == 8'h05;
   endsequence
   // Write to the VLAN register, then read it back alone
   property p_vln_back;
      s_wr_vln ##1 s_rd_vln |=>
         reg_rdata == ($past(reg_wdata, 2) & 8'hC0);
   endproperty
   a_dec_one_later: assert property (frm_valid |-> s_dec_next)
      else $error("decision strobe missing");
   a_dec_qualified: assert property (
      !dec_valid |-> !size_drop && !vlan_cross_drop)
      else $error("decision flag without strobe");
   a_over_huge: assert property (
      frm_valid && frm_len > 11'h77C |=> size_drop)
      else $error("frame over 1916 kept");
   a_short_kept: assert property (
      frm_valid && frm_len <= 11'h5EE |=> !size_drop)
      else $error("short frame dropped");
   a_cross_unknown: assert property (
      frm_valid && frm_cross_vlan && !frm_known_ucast |=> vlan_cross_drop)
      else $error("unknown frame crossed");
   a_bcast_storm: assert property (
      frm_valid && frm_da_bcast |=> storm_regulated)
      else $error("broadcast not regulated");
   a_few_col: assert property (
      col_event && col_count < 5'h10 |=> col_valid && !excess_drop)
      else $error("early collision drop");
   a_bit0_zero: assert property (reg_rd |=> reg_rdata[0] == 1'b0)
      else $error("reserved bit read one");
   a_vln_back: assert property (p_vln_back)
      else $error("vlan register readback");
endmodule : swgc_global_ctrl_monitor
bind swgc_global_ctrl swgc_global_ctrl_monitor swgc_global_ctrl_monitor_i (
   .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .frm_valid(frm_valid), .frm_len(frm_len), .frm_da_bcast(frm_da_bcast),
   .frm_known_ucast(frm_known_ucast), .frm_cross_vlan(frm_cross_vlan),
   .col_event(col_event), .col_count(col_count), .dec_valid(dec_valid),
   .size_drop(size_drop), .vlan_cross_drop(vlan_cross_drop),
   .storm_regulated(storm_regulated), .col_valid(col_valid),
   .excess_drop(excess_drop));
`default_nettype wire

//--- sim/tb_swgc_global_ctrl.sv
// Bench for the global control bank: drives all inputs at the falling
// edge and compares every result with a model. Assumes rtl compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_swgc_global_ctrl;
   import swgc_pkg::*;
   // ==========================================================
   // Stimulus, observation and model state
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic strap = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic frm_valid = 1'b0;
   logic [10:0] frm_len = 11'h000;
   logic [8:0] at = 9'h000;
   logic col_event = 1'b0;
   logic [4:0] col_count = 5'h00;
   wire [7:0] reg_rdata;
   wire [6:0] dec;
   wire [2:0] col;
   wire [2:0] lvl;
   logic [7:0] fwd;
   logic [7:0] vln;
   int lens[8] = '{1518, 1519, 1522, 1523, 1536, 1537, 1916, 1917};
   int cnts[4] = '{15, 16, 17, 31};
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   int i;
   int j;
   int k;
   swgc_global_ctrl swgc_global_ctrl_i (
      .clock(clock), .rst_n(rst_n), .collision_policy_strap_pin(strap),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
      .frm_len(frm_len), .frm_tagged(at[8]), .frm_special_tag(at[7]),
      .frm_da_bcast(at[6]), .frm_da_bit40(at[5]), .frm_known_ucast(at[4]),
      .frm_cross_vlan(at[3]), .frm_igmp(at[2]), .frm_src_fc(at[1]),
      .frm_contend(at[0]), .col_event(col_event), .col_count(col_count),
      .dec_valid(dec[6]), .size_drop(dec[5]), .vlan_cross_drop(dec[4]),
      .storm_regulated(dec[3]), .igmp_to_host(dec[2]), .fair_drop(dec[1]),
      .pause_src(dec[0]), .col_valid(col[2]), .excess_drop(col[1]),
      .excess_retry(col[0]), .bp_carrier_mode(lvl[2]),
      .vlan_forward_en(lvl[1]), .igmp_snoop_en(lvl[0]));
   // Clock and hang guard
   always #12.5 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic do_reset(input logic s);
      strap = s;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      frm_valid = 1'b0;
      col_event = 1'b0;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      fwd = {4'hF, s, 3'h0};
      vln = 8'h00;
   endtask : do_reset
   // One cycle of requests, then compare everything against the model
   task automatic op(input logic w, r, input logic [7:0] a, d, input logic f,
      input logic [10:0] l, input logic [8:0] t, input logic c, input logic [4:0] n);
      logic [7:0] rd_e;
      logic [6:0] de;
      logic [2:0] ce;
      int lim;
      logic drop_e;
      rd_e = (a == 8'h04) ? fwd : (a == 8'h05) ? vln : 8'h00;
      lim = fwd[2] ? 1916 : (fwd[1] || t[7]) ? 1536 : t[8] ? 1522 : 1518;
      de = {1'b1, l > lim, t[3] && (fwd[7] || !t[4]), t[6] || (!fwd[6] && t[5]),
         t[2] && vln[6], t[0] && fwd[4] && !t[1], t[0] && !fwd[4] && t[1]};
      drop_e = (n >= 16) && !fwd[3];
      ce = {1'b1, drop_e, !drop_e};
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      frm_valid = f;
      frm_len = l;
      at = t;
      col_event = c;
      col_count = n;
      @(negedge clock);
      chk("levels", {5'h00, fwd[5], vln[7:6]}, {5'h00, lvl});
      if (r)
         chk("reg_rdata", rd_e, reg_rdata);
      chk("decision", f ? de : 8'h00, {1'b0, dec});
      chk("collision", c ? ce : 8'h00, {5'h00, col});
      if (w && a == 8'h04)
         fwd = d & 8'hFE;
      if (w && a == 8'h05)
         vln = d & 8'hC0;
   endtask : op
   task automatic rg(input logic w, r, input logic [7:0] a, d);
      op(w, r, a, d, 1'b0, 11'h000, 9'h000, 1'b0, 5'h00);
   endtask : rg
   // ==========================================================
   // Main sequence
   initial
   begin
      i = $urandom(32'hDC222B94);
      do_reset(1'b0);
      for (i = 3; i < 7; i++)
         rg(1'b0, 1'b1, 8'(i), 8'h00);
      rg(1'b1, 1'b1, 8'h04, 8'hFF);
      rg(1'b1, 1'b1, 8'h04, 8'h00);
      rg(1'b1, 1'b0, 8'h05, 8'hFF);
      rg(1'b0, 1'b1, 8'h05, 8'h00);
      rg(1'b1, 1'b1, 8'h05, 8'h00);
      rg(1'b1, 1'b1, 8'h06, 8'hFF);
      rg(1'b0, 1'b1, 8'h06, 8'h00);
      // Size limits at every boundary
      for (i = 0; i < 4; i++)
      begin
         rg(1'b1, 1'b0, 8'h04, 8'(i * 2));
         for (j = 0; j < 24; j++)
            op(1'b0, 1'b0, 8'h00, 8'h00, 1'b1,
               11'(lens[j % 8]), (j < 8) ? 9'h000 : 9'h040 << (j / 8),
               1'b0, 5'h00);
      end
      // All frame classes under two settings
      for (i = 0; i < 2; i++)
      begin
         rg(1'b1, 1'b0, 8'h04, i ? 8'h00 : 8'hF0);
         rg(1'b1, 1'b0, 8'h05, i ? 8'hC0 : 8'h00);
         for (j = 0; j < 128; j++)
            op(1'b0, 1'b0, 8'h00, 8'h00, 1'b1,
               11'h040, 9'(j), 1'b0, 5'h00);
      end
      // Collision limit with drop and retry policy
      for (i = 0; i < 8; i++)
      begin
         if (i % 4 == 0)
            rg(1'b1, 1'b0, 8'h04, {4'hF, i[2], 3'h0});
         op(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 11'h000, 9'h000, 1'b1,
            5'(cnts[i % 4]));
      end
      for (k = 0; k < 300; k++)
         op($urandom % 4 == 0, $urandom % 3 == 0, 8'(3 + $urandom % 4),
            8'($urandom), 1'($urandom), 11'(1400 + $urandom % 600),
            9'($urandom), 1'($urandom), 5'($urandom));
      do_reset(1'b1);
      rg(1'b0, 1'b1, 8'h04, 8'h00);
      op(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 11'h000, 9'h000,
         1'b1, 5'h10);
      end_of_test();
   end
endmodule : tb_swgc_global_ctrl
`default_nettype wire
